// file: hw/jaedb_map.svh
// register offsets, field limits and timing constants of the jog and dc brake block
`ifndef JAEDB_MAP_SVH
`define JAEDB_MAP_SVH
`define JAEDB_OFS_FUNC_LO 8'h00
`define JAEDB_OFS_FUNC_HI 8'h04
`define JAEDB_OFS_CTRL 8'h08
`define JAEDB_OFS_JOG 8'h0c
`define JAEDB_OFS_FREQ 8'h10
`define JAEDB_OFS_BRAKE 8'h14
`define JAEDB_OFS_STATUS 8'h18
`define JAEDB_FN_JOG 8'h06
`define JAEDB_FN_BRAKE 8'h07
`define JAEDB_SRC_TERM 8'h01
`define JAEDB_JOG_LIMIT 16'h03e8
`define JAEDB_MODE_MAX 8'h05
`define JAEDB_MODE_LIVE 8'h03
`define JAEDB_DLY_MAX 8'h32
`define JAEDB_FORCE_MAX 8'h64
`define JAEDB_JOG_BRAKE_TENTHS 8'h05
`define JAEDB_CLK_NS 50
`define JAEDB_TENTH_NS 100000000
`define JAEDB_TENTH_CYCLES (`JAEDB_TENTH_NS / `JAEDB_CLK_NS)
`endif

// file: hw/jaedb_pkg.sv
// types of the jog and dc brake block
`default_nettype none
package jaedb_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RUN = 6'b000010,
        ST_JOG = 6'b000100,
        ST_RAMPDN = 6'b001000,
        ST_WAIT = 6'b010000,
        ST_BRAKE = 6'b100000
    } jaedb_state_type;
    typedef struct packed {
        logic en;
        logic [15:0] freq;
        logic dcb;
        logic [7:0] level;
        logic jog;
    } jaedb_motor_type;
    typedef struct packed {
        logic [7:0] sync1_term;
        logic [7:0] sync2_term;
        logic [1:0] sync1_run;
        logic [1:0] sync2_run;
        logic [31:0] func_lo;
        logic [31:0] func_hi;
        logic [7:0] src;
        logic kp_run;
        logic [15:0] jog_f;
        logic [7:0] jog_mode;
        logic [15:0] start_f;
        logic [15:0] run_f;
        logic [7:0] dly;
        logic [7:0] force_pct;
        jaedb_state_type st;
        jaedb_motor_type out;
        logic [31:0] cnt;
        logic [7:0] tenths;
        logic jog_brake;
        logic brake_prev;
        logic aw_ok;
        logic [7:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } jaedb_regs_type;
endpackage
`default_nettype wire

// file: hw/jaedb_top.sv
// jog command and external dc brake terminal logic with an axi4-lite register slave
// How it works
// - terminal coded jog enters jog while on, if enabled; leaves when off
// - no jog when jog frequency below start frequency or zero
// - jog needs terminal run source and jog frequency above start and zero
// - jog mode writes above five are refused
// - terminal coded external brake applies dc injection braking while on
// - with brake input off no dc injection braking from it
// - braking delay accepts zero to five seconds in tenths
// - braking force accepts zero to one hundred percent, drives brake level
// - terminal run: brake input on applies dc braking
// - terminal run: brake release ramps output back to run frequency
// - keypad run: brake input on brakes; release leaves output off
// - braking waits the programmed delay after brake input turns on
// - during the delay output is off and the motor coasts
// - jog output capped at ten hertz and applied without ramp
// - modes 0-2 ignore jog while running, 3-5 accept; coast, ramp, brake
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "jaedb_map.svh"
`default_nettype none
module jaedb_top #(
    parameter int TENTH_CYCLES = `JAEDB_TENTH_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] term_in,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    output var jaedb_pkg::jaedb_motor_type motor_o,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    jaedb_pkg::jaedb_regs_type s_q;
    jaedb_pkg::jaedb_regs_type s_d;
    logic [7:0] jog_map;
    logic [7:0] brake_map;
    logic jog_in;
    logic brake_in;
    logic run_cmd;
    logic term_src;
    logic jog_ok;
    logic live_mode;
    logic [1:0] stop_kind;
    logic brake_rise;
    logic tick;

    // terminals whose assigned function code equals fn
    function automatic logic [7:0] code_map(input logic [63:0] codes, input logic [7:0] fn);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            m[i] = (codes[i*8 +: 8] == fn);
        end
        return m;
    endfunction

    // byte lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // one step of a frequency ramp toward target
    function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] tgt);
        if (cur < tgt)
        begin
            return cur + 16'h0001;
        end
        else if (cur > tgt)
        begin
            return cur - 16'h0001;
        end
        return cur;
    endfunction

    always_comb
    begin
        logic [31:0] v;
        v = 32'h00000000;
        s_d = s_q;
        s_d.sync1_term = term_in;
        s_d.sync2_term = s_q.sync1_term;
        s_d.sync1_run = {reverse_run_input, forward_run_input};
        s_d.sync2_run = s_q.sync1_run;
        jog_map = code_map({s_q.func_hi, s_q.func_lo}, `JAEDB_FN_JOG);
        brake_map = code_map({s_q.func_hi, s_q.func_lo}, `JAEDB_FN_BRAKE);
        jog_in = |(s_q.sync2_term & jog_map);
        brake_in = |(s_q.sync2_term & brake_map);
        term_src = (s_q.src == `JAEDB_SRC_TERM);
        run_cmd = term_src ? |s_q.sync2_run : s_q.kp_run;
        jog_ok = term_src && (s_q.jog_f > s_q.start_f) && (s_q.jog_f != 16'h0000);
        live_mode = (s_q.jog_mode >= `JAEDB_MODE_LIVE);
        stop_kind = live_mode ? 2'(s_q.jog_mode - `JAEDB_MODE_LIVE) : s_q.jog_mode[1:0];
        brake_rise = brake_in && !s_q.brake_prev;
        s_d.brake_prev = brake_in;
        tick = (s_q.cnt >= 32'(TENTH_CYCLES - 1));
        s_d.cnt = tick ? 32'h00000000 : s_q.cnt + 32'h00000001;
        s_d.tenths = (tick && s_q.tenths != 8'hff) ? s_q.tenths + 8'h01 : s_q.tenths;
        s_d.out.jog = 1'b0;
        s_d.out.dcb = 1'b0;
        s_d.out.level = 8'h00;
        case (s_q.st)
            jaedb_pkg::ST_IDLE:
            begin
                s_d.out.en = 1'b0;
                s_d.out.freq = 16'h0000;
                if (run_cmd && jog_in && jog_ok)
                begin
                    s_d.st = jaedb_pkg::ST_JOG;
                end
                else if (run_cmd && !jog_in && !brake_in)
                begin
                    s_d.st = jaedb_pkg::ST_RUN;
                end
            end
            jaedb_pkg::ST_RUN:
            begin
                s_d.out.en = 1'b1;
                s_d.out.freq = ramp(s_q.out.freq, s_q.run_f);
                if (!run_cmd)
                begin
                    s_d.st = jaedb_pkg::ST_RAMPDN;
                end
                else if (jog_in && jog_ok && live_mode)
                begin
                    s_d.st = jaedb_pkg::ST_JOG;
                end
                else if (brake_rise)
                begin
                    s_d.st = jaedb_pkg::ST_WAIT;
                end
            end
            jaedb_pkg::ST_JOG:
            begin
                s_d.out.en = 1'b1;
                s_d.out.jog = 1'b1;
                s_d.out.freq = (s_q.jog_f > `JAEDB_JOG_LIMIT) ? `JAEDB_JOG_LIMIT : s_q.jog_f;
                if (!jog_in || !run_cmd)
                begin
                    s_d.out.jog = 1'b0;
                    if (stop_kind == 2'h0)
                    begin
                        s_d.st = jaedb_pkg::ST_IDLE;
                    end
                    else if (stop_kind == 2'h1)
                    begin
                        s_d.st = jaedb_pkg::ST_RAMPDN;
                    end
                    else
                    begin
                        s_d.st = jaedb_pkg::ST_WAIT;
                        s_d.jog_brake = 1'b1;
                    end
                end
            end
            jaedb_pkg::ST_RAMPDN:
            begin
                s_d.out.en = 1'b1;
                s_d.out.freq = ramp(s_q.out.freq, 16'h0000);
                if (brake_rise)
                begin
                    s_d.st = jaedb_pkg::ST_WAIT;
                end
                else if (run_cmd && !jog_in)
                begin
                    s_d.st = jaedb_pkg::ST_RUN;
                end
                else if (s_q.out.freq == 16'h0000)
                begin
                    s_d.st = jaedb_pkg::ST_IDLE;
                end
            end
            jaedb_pkg::ST_WAIT:
            begin
                s_d.out.en = 1'b0;
                s_d.out.freq = 16'h0000;
                if (s_q.tenths >= s_q.dly)
                begin
                    s_d.st = jaedb_pkg::ST_BRAKE;
                end
            end
            jaedb_pkg::ST_BRAKE:
            begin
                s_d.out.en = 1'b0;
                s_d.out.freq = 16'h0000;
                s_d.out.dcb = 1'b1;
                s_d.out.level = s_q.force_pct;
                if (s_q.jog_brake ? (s_q.tenths >= `JAEDB_JOG_BRAKE_TENTHS) : !brake_in)
                begin
                    s_d.out.dcb = 1'b0;
                    s_d.out.level = 8'h00;
                    s_d.jog_brake = 1'b0;
                    // keypad run dropped so the output stays off until run is given again
                    s_d.kp_run = term_src ? s_q.kp_run : 1'b0;
                    s_d.st = (!s_q.jog_brake && term_src && run_cmd) ?
                        jaedb_pkg::ST_RUN : jaedb_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = jaedb_pkg::ST_IDLE;
            end
        endcase
        if (s_d.st != s_q.st)
        begin
            s_d.cnt = 32'h00000000;
            s_d.tenths = 8'h00;
        end
        // write channel
        if (awvalid && s_q.aw_rdy)
        begin
            s_d.aw_ok = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && s_q.w_rdy)
        begin
            s_d.w_ok = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (s_q.bvalid && bready)
        begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid)
        begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = 2'h0;
            if (s_q.awaddr[7:2] == `JAEDB_OFS_FUNC_LO >> 2)
            begin
                s_d.func_lo = merge(s_q.func_lo, s_q.wdata, s_q.wstrb);
            end
            else if (s_q.awaddr[7:2] == `JAEDB_OFS_FUNC_HI >> 2)
            begin
                s_d.func_hi = merge(s_q.func_hi, s_q.wdata, s_q.wstrb);
            end
            else if (s_q.awaddr[7:2] == `JAEDB_OFS_CTRL >> 2)
            begin
                v = merge({23'h000000, s_q.kp_run, s_q.src}, s_q.wdata, s_q.wstrb);
                s_d.src = v[7:0];
                s_d.kp_run = v[8];
            end
            else if (s_q.awaddr[7:2] == `JAEDB_OFS_JOG >> 2)
            begin
                v = merge({8'h00, s_q.jog_mode, s_q.jog_f}, s_q.wdata, s_q.wstrb);
                s_d.jog_f = v[15:0];
                if (v[23:16] <= `JAEDB_MODE_MAX)
                begin
                    s_d.jog_mode = v[23:16];
                end
            end
            else if (s_q.awaddr[7:2] == `JAEDB_OFS_FREQ >> 2)
            begin
                v = merge({s_q.run_f, s_q.start_f}, s_q.wdata, s_q.wstrb);
                s_d.start_f = v[15:0];
                s_d.run_f = v[31:16];
            end
            else if (s_q.awaddr[7:2] == `JAEDB_OFS_BRAKE >> 2)
            begin
                v = merge({16'h0000, s_q.force_pct, s_q.dly}, s_q.wdata, s_q.wstrb);
                if (v[7:0] <= `JAEDB_DLY_MAX)
                begin
                    s_d.dly = v[7:0];
                end
                if (v[15:8] <= `JAEDB_FORCE_MAX)
                begin
                    s_d.force_pct = v[15:8];
                end
            end
            else if (s_q.awaddr[7:2] != `JAEDB_OFS_STATUS >> 2)
            begin
                s_d.bresp = 2'h2;
            end
        end
        // read channel
        if (s_q.rvalid && rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.ar_rdy)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = 2'h0;
            if (araddr[7:2] == `JAEDB_OFS_FUNC_LO >> 2)
            begin
                s_d.rdata = s_q.func_lo;
            end
            else if (araddr[7:2] == `JAEDB_OFS_FUNC_HI >> 2)
            begin
                s_d.rdata = s_q.func_hi;
            end
            else if (araddr[7:2] == `JAEDB_OFS_CTRL >> 2)
            begin
                s_d.rdata = {23'h000000, s_q.kp_run, s_q.src};
            end
            else if (araddr[7:2] == `JAEDB_OFS_JOG >> 2)
            begin
                s_d.rdata = {8'h00, s_q.jog_mode, s_q.jog_f};
            end
            else if (araddr[7:2] == `JAEDB_OFS_FREQ >> 2)
            begin
                s_d.rdata = {s_q.run_f, s_q.start_f};
            end
            else if (araddr[7:2] == `JAEDB_OFS_BRAKE >> 2)
            begin
                s_d.rdata = {16'h0000, s_q.force_pct, s_q.dly};
            end
            else if (araddr[7:2] == `JAEDB_OFS_STATUS >> 2)
            begin
                s_d.rdata = {2'h0, s_q.st, s_q.out.jog, s_q.out.dcb, s_q.out.en, 5'h00,
                    s_q.out.freq};
            end
            else
            begin
                s_d.rdata = 32'h00000000;
                s_d.rresp = 2'h2;
            end
        end
        s_d.aw_rdy = !s_d.aw_ok && !s_d.bvalid;
        s_d.w_rdy = !s_d.w_ok && !s_d.bvalid;
        s_d.ar_rdy = !s_d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.st <= jaedb_pkg::ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign motor_o = s_q.out;
    assign awready = s_q.aw_rdy;
    assign wready = s_q.w_rdy;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.ar_rdy;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence brake_release_s;
        s_q.st == jaedb_pkg::ST_BRAKE && !s_q.jog_brake && !brake_in;
    endsequence

    jog_entry_a: assert property ($rose(s_q.st == jaedb_pkg::ST_JOG) |->
        $past(term_src) && $past(s_q.jog_f) > $past(s_q.start_f))
        else $error("jog entered without its conditions");
    jog_zero_a: assert property (s_q.jog_f == 16'h0000 && s_q.st != jaedb_pkg::ST_JOG
        |=> s_q.st != jaedb_pkg::ST_JOG)
        else $error("jog with zero jog frequency");
    jog_cap_a: assert property (s_q.st == jaedb_pkg::ST_JOG |=>
        s_q.out.freq <= `JAEDB_JOG_LIMIT && s_q.out.en)
        else $error("jog output above ten hertz");
    jog_live_a: assert property ($past(s_q.st) == jaedb_pkg::ST_RUN
        && s_q.st == jaedb_pkg::ST_JOG |-> $past(s_q.jog_mode) >= `JAEDB_MODE_LIVE)
        else $error("jog taken while running in an ignoring mode");
    coast_wait_a: assert property (s_q.st == jaedb_pkg::ST_WAIT |=>
        !s_q.out.en && !s_q.out.dcb)
        else $error("output driven during brake delay");
    brake_delay_a: assert property ($past(s_q.st) == jaedb_pkg::ST_WAIT
        && s_q.st == jaedb_pkg::ST_BRAKE |-> $past(s_q.tenths) >= $past(s_q.dly))
        else $error("braking before delay expired");
    brake_drop_a: assert property (brake_release_s |=>
        s_q.st != jaedb_pkg::ST_BRAKE ##1 !s_q.out.dcb)
        else $error("braking kept after brake input off");
    keypad_off_a: assert property (brake_release_s and !term_src |=>
        s_q.st == jaedb_pkg::ST_IDLE ##1 !s_q.out.en ##1 !s_q.out.en)
        else $error("output restarted after keypad brake release");
    term_resume_a: assert property (brake_release_s and term_src and run_cmd |=>
        s_q.st == jaedb_pkg::ST_RUN ##1 s_q.out.en)
        else $error("no ramp back after terminal brake release");
    cfg_range_a: assert property (s_q.jog_mode <= `JAEDB_MODE_MAX &&
        s_q.dly <= `JAEDB_DLY_MAX && s_q.force_pct <= `JAEDB_FORCE_MAX)
        else $error("configuration outside its range");
endmodule
`default_nettype wire

// file: tb/jaedb_operator.sv
// operator model driving the jog, brake, stray and run terminals
`timescale 1ns/1ps
`default_nettype none
module jaedb_operator (
    input wire logic aclk,
    input wire logic want_jog,
    input wire logic want_run,
    input wire logic want_brake,
    input wire logic want_stray,
    output var logic [7:0] term_in,
    output var logic forward_run_input,
    output var logic reverse_run_input
);
    logic jog_q;
    initial
    begin
        jog_q = 1'b0;
        forward_run_input = 1'b0;
        reverse_run_input = 1'b0;
    end
    always @(posedge aclk)
    begin
        jog_q <= want_jog;
        // when jog is wanted, run rises only once the jog pin is already on
        forward_run_input <= want_run & (forward_run_input | ~want_jog | jog_q);
    end
    assign term_in = {5'h00, want_stray, want_brake, jog_q};
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking testbench of the jog and dc brake block
`timescale 1ns/1ps
`include "jaedb_map.svh"
`default_nettype none
module tb;
    localparam int J = 0;
    localparam int D = 1;
    localparam int E = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic want_jog = 1'b0;
    logic want_run = 1'b0;
    logic want_brake = 1'b0;
    logic want_stray = 1'b0;
    logic [7:0] term_in;
    logic fwd;
    logic rev;
    jaedb_pkg::jaedb_motor_type motor_o;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;

    always #25 aclk = ~aclk;

    jaedb_operator op (.aclk(aclk), .want_jog(want_jog), .want_run(want_run),
        .want_brake(want_brake), .want_stray(want_stray), .term_in(term_in),
        .forward_run_input(fwd), .reverse_run_input(rev));

    jaedb_top #(.TENTH_CYCLES(4)) uut (.aclk(aclk), .aresetn(aresetn), .term_in(term_in),
        .forward_run_input(fwd), .reverse_run_input(rev), .motor_o(motor_o),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            miscompares++;
            $display("[FAIL] %0t wait ran out got %h exp %h", $time, n, lim);
            end_sim();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50)
        begin
            @(posedge aclk);
            n++;
            if (awready && awvalid)
                awvalid <= 1'b0;
            if (wready && wvalid)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er});
                n = 0;
                break;
            end
        end
        tmo(n, 50);
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50)
        begin
            @(posedge aclk);
            n++;
            if (arready && arvalid)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                rready <= 1'b0;
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
                n = 0;
                break;
            end
        end
        tmo(n, 50);
        @(posedge aclk);
    endtask

    function automatic logic [15:0] mval(input int sel);
        case (sel)
            0: return {15'h0, motor_o.jog};
            1: return {15'h0, motor_o.dcb};
            2: return {15'h0, motor_o.en};
            default: return motor_o.freq;
        endcase
    endfunction

    task automatic wait_m(input int sel, input logic [15:0] v, input int lim);
        int n;
        n = 0;
        while (n < lim)
        begin
            @(posedge aclk);
            n++;
            if (mval(sel) === v)
            begin
                n = 0;
                break;
            end
        end
        cmp_count++;
        tmo(n, lim);
    endtask

    task automatic hold_m(input int sel, input logic [15:0] v, input int cyc);
        cmp_count++;
        repeat (cyc)
        begin
            @(posedge aclk);
            if (mval(sel) !== v)
            begin
                chk({16'h0, mval(sel)}, {16'h0, v});
                break;
            end
        end
    endtask

    task automatic sc_regs;
        axi_rd(`JAEDB_OFS_CTRL, 32'h0, 2'b00);
        axi_rd(`JAEDB_OFS_STATUS, 32'h0100_0000, 2'b00);
        axi_rd(8'h1c, 32'h0, 2'b10);
        axi_wr(8'h1c, 32'h1, 2'b10);
        axi_wr(`JAEDB_OFS_STATUS, 32'hffff_ffff, 2'b00);
        axi_rd(`JAEDB_OFS_STATUS, 32'h0100_0000, 2'b00);
        axi_wr(`JAEDB_OFS_JOG, 32'h0005_01f4, 2'b00);
        axi_wr(`JAEDB_OFS_JOG, 32'h0006_01f4, 2'b00);
        axi_rd(`JAEDB_OFS_JOG, 32'h0005_01f4, 2'b00);
        axi_wr(`JAEDB_OFS_BRAKE, 32'h0000_6432, 2'b00);
        axi_wr(`JAEDB_OFS_BRAKE, 32'h0000_6533, 2'b00);
        axi_rd(`JAEDB_OFS_BRAKE, 32'h0000_6432, 2'b00);
        axi_wr(`JAEDB_OFS_BRAKE, 32'h0000_6402, 2'b00);
        axi_wr(`JAEDB_OFS_FUNC_LO, 32'h0000_0706, 2'b00);
        axi_wr(`JAEDB_OFS_FREQ, 32'h00c8_0064, 2'b00);
        axi_wr(`JAEDB_OFS_CTRL, 32'h0000_0001, 2'b00);
    endtask

    task automatic sc_jog_modes;
        for (int m = 0; m < 6; m++)
        begin
            axi_wr(`JAEDB_OFS_JOG, {8'h00, 8'(m), 16'h01f4}, 2'b00);
            want_jog <= 1'b1;
            want_run <= 1'b1;
            wait_m(J, 16'h1, 20);
            chk({16'h0, motor_o.freq}, 32'h01f4);
            want_jog <= 1'b0;
            want_run <= 1'b0;
            if (m % 3 == 0)
                wait_m(E, 16'h0, 10);
            else if (m % 3 == 1)
                hold_m(E, 16'h1, 5);
            else
                wait_m(D, 16'h1, 30);
            wait_m(E, 16'h0, 700);
            wait_m(D, 16'h0, 60);
        end
    endtask

    task automatic sc_jog_refused;
        axi_wr(`JAEDB_OFS_JOG, 32'h0000_0032, 2'b00);
        want_jog <= 1'b1;
        want_run <= 1'b1;
        hold_m(J, 16'h0, 20);
        want_jog <= 1'b0;
        want_run <= 1'b0;
        wait_m(E, 16'h0, 400);
        axi_wr(`JAEDB_OFS_JOG, 32'h0000_01f4, 2'b00);
        want_run <= 1'b1;
        wait_m(16'h3, 16'h00c8, 300);
        want_jog <= 1'b1;
        hold_m(J, 16'h0, 20);
        want_jog <= 1'b0;
        axi_wr(`JAEDB_OFS_JOG, 32'h0003_01f4, 2'b00);
        want_jog <= 1'b1;
        wait_m(J, 16'h1, 20);
        want_jog <= 1'b0;
        want_run <= 1'b0;
        wait_m(E, 16'h0, 700);
    endtask

    task automatic sc_brake_term;
        want_run <= 1'b1;
        wait_m(3, 16'h00c8, 300);
        want_stray <= 1'b1;
        hold_m(E, 16'h1, 10);
        want_stray <= 1'b0;
        want_brake <= 1'b1;
        wait_m(E, 16'h0, 8);
        hold_m(D, 16'h0, 4);
        wait_m(D, 16'h1, 20);
        chk({24'h0, motor_o.level}, 32'h64);
        want_brake <= 1'b0;
        wait_m(3, 16'h00c8, 300);
        want_run <= 1'b0;
        hold_m(D, 16'h0, 250);
        wait_m(E, 16'h0, 100);
    endtask

    task automatic sc_brake_keypad;
        axi_wr(`JAEDB_OFS_CTRL, 32'h0000_0100, 2'b00);
        wait_m(3, 16'h00c8, 300);
        want_brake <= 1'b1;
        wait_m(D, 16'h1, 30);
        want_brake <= 1'b0;
        wait_m(D, 16'h0, 20);
        hold_m(E, 16'h0, 40);
        axi_wr(`JAEDB_OFS_CTRL, 32'h0000_0001, 2'b00);
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        sc_regs();
        sc_jog_modes();
        sc_jog_refused();
        sc_brake_term();
        sc_brake_keypad();
        end_sim();
    end
endmodule
`default_nettype wire
